/* core/rcs_top.sv */
// Reset-cause recording block with AHB-Lite register slave
//
// Function
// - Master clear in a run power mode restarts at zero and sets the time-out flag only.
// - Master clear in idle or sleep restarts at zero, sets time-out and clears power-down.
// - Watchdog time-out at full power or run mode restarts at zero and clears time-out.
// - Master clear at full power restarts at zero and changes no flag.
// - With stack reset enabled, a full stack resets to zero and sets the stack full flag.
// - With stack reset enabled, an underflow resets to zero and sets the underflow flag.
// - With stack reset disabled, an underflow only sets the underflow flag.
// - Watchdog time-out in idle or sleep wakes at PC plus two, clearing time-out and power-down.
// - Interrupt wake clears power-down and goes to a vector if a global enable is set, else PC+2.
// - Control bit 7 selects two priority levels when one, single level when zero.
// - Control bit 6 reads zero, bit 5 is the mismatch flag, bits 4 to 0 the other flags.
// - Mismatch reset clears the mismatch flag; power-on and brownout set it, no other reset touches it.
// - Configuration is compared with a complement shadow and a mismatch forces a reset.
//
// The AHB-Lite register port and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
module rcs_top (
    // Clock and power-on reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Reset and wake sources, asynchronous pulses
    input wire logic brownout_in,
    input wire logic master_clear_pin,
    input wire logic watchdog_timeout,
    // Core-side events, same clock
    input wire logic reset_instr,
    input wire logic stack_full_evt,
    input wire logic stack_underflow_evt,
    input wire logic wake_irq,
    input wire logic wake_irq_high,
    input wire logic [1:0] power_mode,
    input wire logic high_priority_global_enable,
    input wire logic low_priority_global_enable,
    input wire logic [20:0] current_pc,
    // Outputs
    output logic core_reset,
    output logic pc_load,
    output logic [20:0] pc_value,
    output logic priority_levels_enable,
    output logic irq
);
    // ========================================
    // State
    typedef struct packed {
        logic [7:0] ctrl;
        logic [1:0] stk;
        logic stack_overflow_reset_enable;
        logic [7:0] stat;
        logic [7:0] mask;
        logic [15:0] cfg;
        logic [15:0] shadow;
        logic [20:0] pcv;
        logic pc_load;
        logic core_reset;
        logic irq;
        logic prio;
        logic [2:0] sync_prev;
        logic dph;
        logic dwr;
        logic [7:0] daddr;
        logic [31:0] rdata;
    } rcs_top_s;
    rcs_top_s st_reg;
    rcs_top_s st_next;

    logic [2:0] pin_sync;
    logic [2:0] pin_rise;
    logic bor_ev;
    logic master_clear_pin_ev;
    logic wdt_ev;
    logic cm_ev;
    logic wr_hit;
    logic [rcs_pkg::RCS_EV_N-1:0] ev;
    logic [31:0] rd_mux;

    // ========================================
    // Pin synchronisers
    rcs_sync #(
        .WIDTH(3)
    ) u_sync (
        .hclk(hclk),
        .hresetn(hresetn),
        .d({watchdog_timeout, master_clear_pin, brownout_in}),
        .q(pin_sync)
    );

    // Edge detect after the second flop only
    assign pin_rise = pin_sync & ~st_reg.sync_prev;
    assign bor_ev = pin_rise[0];
    assign master_clear_pin_ev = pin_rise[1];
    assign wdt_ev = pin_rise[2];
    // Shadow holds the complement; any disagreement is a mismatch
    assign cm_ev = (st_reg.cfg != ~st_reg.shadow);

    // Event vector for the sticky status
    always_comb begin
        ev = '0;
        ev[rcs_pkg::RCS_EV_BOR] = bor_ev;
        ev[rcs_pkg::RCS_EV_RESETI] = reset_instr;
        ev[rcs_pkg::RCS_EV_MASTER_CLEAR_PIN] = master_clear_pin_ev;
        ev[rcs_pkg::RCS_EV_WDT] = wdt_ev;
        ev[rcs_pkg::RCS_EV_STACK] = st_reg.stack_overflow_reset_enable & (stack_full_evt | stack_underflow_evt);
        ev[rcs_pkg::RCS_EV_WAKE] = wake_irq && power_mode != 2'(rcs_pkg::RCS_MODE_FULL);
        ev[rcs_pkg::RCS_EV_CM] = cm_ev;
        ev[rcs_pkg::RCS_EV_UNDERERR] = ~st_reg.stack_overflow_reset_enable & stack_underflow_evt;
    end

    assign wr_hit = st_reg.dph & st_reg.dwr;

    // Read data multiplexer, unmapped reads give zero
    always_comb begin
        rd_mux = '0;
        unique case (haddr)
            rcs_pkg::RCS_ADDR_CTRL: rd_mux[7:0] = st_reg.ctrl & rcs_pkg::RCS_CTRL_WMASK
                | (st_reg.ctrl & 8'h0c);
            rcs_pkg::RCS_ADDR_STACK: rd_mux[2:0] = {st_reg.stack_overflow_reset_enable, st_reg.stk};
            rcs_pkg::RCS_ADDR_IRQ_STAT: rd_mux[7:0] = st_reg.stat;
            rcs_pkg::RCS_ADDR_IRQ_MASK: rd_mux[7:0] = st_reg.mask;
            rcs_pkg::RCS_ADDR_PC: rd_mux[20:0] = st_reg.pcv;
            rcs_pkg::RCS_ADDR_CFG: rd_mux[31:0] = {st_reg.shadow, st_reg.cfg};
            default: rd_mux = '0;
        endcase
    end

    // ========================================
    // Next-state logic: bus writes first, hardware events override
    always_comb begin
        st_next = st_reg;
        st_next.pc_load = 1'b0;
        st_next.core_reset = 1'b0;
        st_next.sync_prev = pin_sync;
        // Address phase capture; zero wait states
        st_next.dph = hsel && hready && htrans[1];
        st_next.dwr = hwrite;
        st_next.daddr = haddr;
        if (hsel && hready && htrans[1] && !hwrite) begin
            st_next.rdata = rd_mux;
        end
        // Software writes
        if (wr_hit) begin
            unique case (st_reg.daddr)
                rcs_pkg::RCS_ADDR_CTRL: begin
                    // TO and PD are read-only; bit 6 stays zero
                    st_next.ctrl = (st_reg.ctrl & ~rcs_pkg::RCS_CTRL_WMASK)
                        | (hwdata[7:0] & rcs_pkg::RCS_CTRL_WMASK);
                end
                rcs_pkg::RCS_ADDR_STACK: begin
                    st_next.stk = st_reg.stk & ~hwdata[1:0];
                    st_next.stack_overflow_reset_enable = hwdata[rcs_pkg::RCS_BIT_STACK_OVERFLOW_RESET_ENABLE];
                end
                rcs_pkg::RCS_ADDR_IRQ_STAT: st_next.stat = st_reg.stat & ~hwdata[7:0];
                rcs_pkg::RCS_ADDR_IRQ_MASK: st_next.mask = hwdata[7:0];
                rcs_pkg::RCS_ADDR_CFG: begin
                    st_next.cfg = hwdata[15:0];
                    st_next.shadow = hwdata[31:16];
                end
                default: st_next.stat = st_next.stat;
            endcase
        end
        // Sticky status: set wins over clear
        st_next.stat = st_next.stat | ev;
        // Reset and wake sources, one handled per cycle by priority
        if (bor_ev) begin
            st_next.ctrl[rcs_pkg::RCS_BIT_CM] = 1'b1;
            st_next.ctrl[rcs_pkg::RCS_BIT_RI] = 1'b1;
            st_next.ctrl[rcs_pkg::RCS_BIT_TO] = 1'b1;
            st_next.ctrl[rcs_pkg::RCS_BIT_PD] = 1'b1;
            st_next.ctrl[rcs_pkg::RCS_BIT_BOR] = 1'b0;
            st_next.ctrl[rcs_pkg::RCS_BIT_PRIO] = 1'b0;  // Priority levels off again
            st_next.pcv = rcs_pkg::RCS_VEC_RESET;
            st_next.core_reset = 1'b1;
        end else if (cm_ev) begin
            st_next.ctrl[rcs_pkg::RCS_BIT_CM] = 1'b0;
            st_next.cfg = ~st_reg.shadow;  // Reload restores agreement
            st_next.pcv = rcs_pkg::RCS_VEC_RESET;
            st_next.core_reset = 1'b1;
        end else if (master_clear_pin_ev) begin
            unique case (power_mode)
                2'(rcs_pkg::RCS_MODE_RUN): st_next.ctrl[rcs_pkg::RCS_BIT_TO] = 1'b1;
                2'(rcs_pkg::RCS_MODE_IDLE): begin
                    st_next.ctrl[rcs_pkg::RCS_BIT_TO] = 1'b1;
                    st_next.ctrl[rcs_pkg::RCS_BIT_PD] = 1'b0;
                end
                default: st_next.ctrl = st_next.ctrl;  // Full power: no change
            endcase
            st_next.pcv = rcs_pkg::RCS_VEC_RESET;
            st_next.core_reset = 1'b1;
        end else if (wdt_ev) begin
            st_next.ctrl[rcs_pkg::RCS_BIT_TO] = 1'b0;
            if (power_mode == 2'(rcs_pkg::RCS_MODE_IDLE)) begin
                st_next.ctrl[rcs_pkg::RCS_BIT_PD] = 1'b0;  // Wake, no restart
                st_next.pcv = 21'(current_pc + rcs_pkg::RCS_PC_STEP);
            end else begin
                st_next.pcv = rcs_pkg::RCS_VEC_RESET;
                st_next.core_reset = 1'b1;
            end
        end else if (reset_instr) begin
            st_next.ctrl[rcs_pkg::RCS_BIT_RI] = 1'b0;
            st_next.pcv = rcs_pkg::RCS_VEC_RESET;
            st_next.core_reset = 1'b1;
        end else if (st_reg.stack_overflow_reset_enable && stack_full_evt) begin
            st_next.stk[rcs_pkg::RCS_BIT_STKFULL] = 1'b1;
            st_next.pcv = rcs_pkg::RCS_VEC_RESET;
            st_next.core_reset = 1'b1;
        end else if (stack_underflow_evt) begin
            st_next.stk[rcs_pkg::RCS_BIT_STKUNDER] = 1'b1;
            if (st_reg.stack_overflow_reset_enable) begin
                st_next.pcv = rcs_pkg::RCS_VEC_RESET;
                st_next.core_reset = 1'b1;
            end
        end else if (ev[rcs_pkg::RCS_EV_WAKE]) begin
            st_next.ctrl[rcs_pkg::RCS_BIT_PD] = 1'b0;
            if (high_priority_global_enable || low_priority_global_enable) begin
                // Single-level mode always uses the high vector
                st_next.pcv = (wake_irq_high || !st_reg.ctrl[rcs_pkg::RCS_BIT_PRIO])
                    ? rcs_pkg::RCS_VEC_HIGH : rcs_pkg::RCS_VEC_LOW;
            end else begin
                st_next.pcv = 21'(current_pc + rcs_pkg::RCS_PC_STEP);
            end
        end
        // Every reset or wake loads the program counter; an underflow error is neither
        st_next.pc_load = bor_ev | cm_ev | master_clear_pin_ev | wdt_ev | reset_instr
            | (st_reg.stack_overflow_reset_enable & (stack_full_evt | stack_underflow_evt))
            | ev[rcs_pkg::RCS_EV_WAKE];
        st_next.prio = st_next.ctrl[rcs_pkg::RCS_BIT_PRIO];
        st_next.ctrl[6] = 1'b0;
        st_next.irq = |(st_next.stat & st_next.mask);
    end

    // State register; power-on reset state
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_reg <= '0;
            st_reg.ctrl <= rcs_pkg::RCS_CTRL_POR;
            st_reg.shadow <= 16'hffff;
            st_reg.stack_overflow_reset_enable <= 1'b1;
            st_reg.core_reset <= 1'b1;
            st_reg.pc_load <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    // ========================================
    // Outputs
    assign hrdata = st_reg.rdata;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign core_reset = st_reg.core_reset;
    assign pc_load = st_reg.pc_load;
    assign pc_value = st_reg.pcv;
    assign priority_levels_enable = st_reg.prio;
    assign irq = st_reg.irq;

    // ========================================
    // Assertions
    master_clear_pin_run_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (master_clear_pin_ev && !bor_ev && !cm_ev && power_mode == 2'b01)
        |=> (st_reg.ctrl[3] && st_reg.core_reset && st_reg.pcv == 21'h0))
        else $error("master_clear_pin in run mode wrong");
    master_clear_pin_idle_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (master_clear_pin_ev && !bor_ev && !cm_ev && power_mode == 2'b11)
        |=> (st_reg.ctrl[3:2] == 2'b10))
        else $error("master_clear_pin in idle wrong");
    wdt_run_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (wdt_ev && !bor_ev && !cm_ev && !master_clear_pin_ev && power_mode != 2'b11)
        |=> (!st_reg.ctrl[3] && st_reg.core_reset))
        else $error("wdt reset wrong");
    master_clear_pin_full_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (master_clear_pin_ev && !bor_ev && !cm_ev && power_mode == 2'b00 && !st_reg.dph)
        |=> (st_reg.ctrl == $past(st_reg.ctrl)))
        else $error("master_clear_pin full power changed flags");
    wdt_wake_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (wdt_ev && !bor_ev && !cm_ev && !master_clear_pin_ev && power_mode == 2'b11)
        |=> (st_reg.ctrl[3:2] == 2'b00 && !st_reg.core_reset
            && st_reg.pcv == 21'($past(current_pc) + 21'h2)))
        else $error("wdt wake wrong");
    under_noreset_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (stack_underflow_evt && !st_reg.stack_overflow_reset_enable && !bor_ev && !cm_ev && !master_clear_pin_ev
            && !wdt_ev && !reset_instr)
        |=> (st_reg.stk[1] && !st_reg.core_reset))
        else $error("underflow without reset wrong");
    bit6_zero_a: assert property (@(posedge hclk) disable iff (!hresetn)
        !st_reg.ctrl[6])
        else $error("control bit 6 set");
    cm_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (cm_ev && !bor_ev) |=> (!st_reg.ctrl[5] && st_reg.core_reset))
        else $error("mismatch reset wrong");
    irq_level_a: assert property (@(posedge hclk) disable iff (!hresetn)
        irq == |(st_reg.stat & st_reg.mask))
        else $error("irq mismatch");
    // Stack, software and brownout restarts; underflow error loads no PC
    stk_full_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (stack_full_evt && st_reg.stack_overflow_reset_enable && !bor_ev && !cm_ev && !master_clear_pin_ev && !wdt_ev
            && !reset_instr)
        |=> (st_reg.stk[0] && st_reg.core_reset && st_reg.pcv == 21'h0))
        else $error("stack full reset wrong");
    stk_under_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (stack_underflow_evt && st_reg.stack_overflow_reset_enable && !stack_full_evt && !bor_ev && !cm_ev
            && !master_clear_pin_ev && !wdt_ev && !reset_instr)
        |=> (st_reg.stk[1] && st_reg.core_reset && st_reg.pcv == 21'h0))
        else $error("stack underflow reset wrong");
    under_noload_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (stack_underflow_evt && !st_reg.stack_overflow_reset_enable && !bor_ev && !cm_ev && !master_clear_pin_ev && !wdt_ev
            && !reset_instr && !wake_irq)
        |=> !st_reg.pc_load)
        else $error("underflow error loaded pc");
    reset_instr_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (reset_instr && !bor_ev && !cm_ev && !master_clear_pin_ev && !wdt_ev)
        |=> (!st_reg.ctrl[4] && st_reg.core_reset && st_reg.pcv == 21'h0))
        else $error("reset instruction wrong");
    brownout_a: assert property (@(posedge hclk) disable iff (!hresetn)
        bor_ev |=> (st_reg.ctrl[7:2] == 6'b001111 && !st_reg.ctrl[0] && st_reg.core_reset))
        else $error("brownout flags wrong");
    // Wake, mismatch and priority outcomes
    wake_vec_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (wake_irq && power_mode != 2'b00 && !bor_ev && !cm_ev && !master_clear_pin_ev && !wdt_ev
            && !reset_instr && !stack_full_evt && !stack_underflow_evt
            && (high_priority_global_enable || low_priority_global_enable))
        |=> (!st_reg.ctrl[2] && !st_reg.core_reset
            && (st_reg.pcv == 21'h8 || st_reg.pcv == 21'h18)))
        else $error("interrupt wake wrong");
    cm_reload_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (cm_ev && !bor_ev) |=> (st_reg.cfg == ~st_reg.shadow && st_reg.pcv == 21'h0))
        else $error("mismatch reload wrong");
    prio_copy_a: assert property (@(posedge hclk) disable iff (!hresetn)
        priority_levels_enable == st_reg.ctrl[7])
        else $error("priority enable wrong");
endmodule

/* core/rcs_pkg.sv */
// Package of constants for the reset-cause status block
package rcs_pkg;
    // ========================================
    // Register map (byte addresses)
    localparam logic [7:0] RCS_ADDR_CTRL = 8'h00;  // reset_cause_control
    localparam logic [7:0] RCS_ADDR_STACK = 8'h04;  // stack flags + enable
    localparam logic [7:0] RCS_ADDR_IRQ_STAT = 8'h08;
    localparam logic [7:0] RCS_ADDR_IRQ_MASK = 8'h0c;
    localparam logic [7:0] RCS_ADDR_PC = 8'h10;  // restart/resume address
    localparam logic [7:0] RCS_ADDR_CFG = 8'h14;  // configuration word
    // ========================================
    // Field positions of reset_cause_control
    localparam int RCS_BIT_PRIO = 7;
    localparam int RCS_BIT_CM = 5;
    localparam int RCS_BIT_RI = 4;
    localparam int RCS_BIT_TO = 3;
    localparam int RCS_BIT_PD = 2;
    localparam int RCS_BIT_POR = 1;
    localparam int RCS_BIT_BOR = 0;
    // Writable bits of reset_cause_control (bit 6 unimplemented)
    localparam logic [7:0] RCS_CTRL_WMASK = 8'hb3;
    // Value after power-on: 0-11 1100
    localparam logic [7:0] RCS_CTRL_POR = 8'h3c;
    // Stack register fields
    localparam int RCS_BIT_STKFULL = 0;
    localparam int RCS_BIT_STKUNDER = 1;
    localparam int RCS_BIT_STACK_OVERFLOW_RESET_ENABLE = 2;
    // ========================================
    // Event numbers (status/mask bit positions)
    localparam int RCS_EV_N = 8;
    localparam int RCS_EV_BOR = 0;
    localparam int RCS_EV_RESETI = 1;
    localparam int RCS_EV_MASTER_CLEAR_PIN = 2;
    localparam int RCS_EV_WDT = 3;
    localparam int RCS_EV_STACK = 4;
    localparam int RCS_EV_WAKE = 5;
    localparam int RCS_EV_CM = 6;
    localparam int RCS_EV_UNDERERR = 7;
    // ========================================
    // Vectors
    localparam logic [20:0] RCS_VEC_RESET = 21'h000000;
    localparam logic [20:0] RCS_VEC_HIGH = 21'h000008;
    localparam logic [20:0] RCS_VEC_LOW = 21'h000018;
    localparam logic [20:0] RCS_PC_STEP = 21'h000002;
    localparam int RCS_PC_W = 21;
    // Power modes
    typedef enum logic [1:0] {
        RCS_MODE_FULL = 2'b00,
        RCS_MODE_RUN = 2'b01,
        RCS_MODE_IDLE = 2'b11
    } rcs_mode_e;
endpackage

/* core/rcs_sync.sv */
// Two-flop synchroniser bank for asynchronous event inputs
`timescale 1ns/10ps
module rcs_sync #(
    parameter int WIDTH = 8
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Data
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
    } rcs_sync_s;
    rcs_sync_s st_reg;
    rcs_sync_s st_next;

    // Shift through two stages; first stage feeds only the second
    always_comb begin
        st_next.s1 = d;
        st_next.s2 = st_reg.s1;
    end

    // State register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign q = st_reg.s2;
endmodule

/* test/rcs_top_test.sv */
// Self-checking testbench for the reset-cause status block
`timescale 1ns/10ps
module rcs_top_test;
    // ========================================
    // Stimulus and observed signals
    localparam int MAX_CYCLES = 8000;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [7:0] haddr = 8'h00;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic [6:0] ev_drv = 7'h00;
    logic wake_high = 1'b0;
    logic [1:0] power_mode = 2'h0;
    logic gie_h = 1'b0;
    logic gie_l = 1'b0;
    logic [20:0] current_pc = 21'h0;
    logic [31:0] hrdata;
    logic hreadyout, hresp, core_reset, pc_load, prio_en, irq;
    logic [20:0] pc_value;
    int mismatches = 0;
    int checks = 0;
    int cycles = 0;
    // Reference copies of what software should read back
    logic [7:0] ctrl_m, mask_m, stat_m;
    logic [2:0] stk_m;
    logic [31:0] r, d, q;
    int n, ev;
    logic [1:0] modes [3] = '{2'h0, 2'h1, 2'h3};

    // Single slave, so its ready is the bus ready
    rcs_top uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .brownout_in(ev_drv[6]),
        .master_clear_pin(ev_drv[1]), .watchdog_timeout(ev_drv[2]), .reset_instr(ev_drv[0]),
        .stack_full_evt(ev_drv[3]), .stack_underflow_evt(ev_drv[4]), .wake_irq(ev_drv[5]),
        .wake_irq_high(wake_high), .power_mode(power_mode),
        .high_priority_global_enable(gie_h), .low_priority_global_enable(gie_l),
        .current_pc(current_pc), .core_reset(core_reset), .pc_load(pc_load),
        .pc_value(pc_value), .priority_levels_enable(prio_en), .irq(irq));

    // ========================================
    // Clock and hang guard
    initial begin
        forever #25 hclk = ~hclk;
    end
    always @(posedge hclk) begin
        cycles <= cycles + 1;
        if (cycles == MAX_CYCLES) begin
            mismatches++;
            report_and_stop();
        end
    end

    // ========================================
    // Reporting and comparison
    task automatic report_and_stop();
        $display("Checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    // ========================================
    // Bus master: address phase, then data phase, each held until ready
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string what);
        ahb(1'b0, a, 32'h0);
        chk(what, exp, q);
    endtask

    // ========================================
    // Reference behaviour of each restart or wake source
    function automatic logic restarts(input int e);
        case (e)
            2: return power_mode != 2'h3;
            4: return stk_m[2];
            5: return 1'b0;
            default: return 1'b1;
        endcase
    endfunction
    function automatic logic [20:0] next_pc(input int e);
        if ((e == 2 && power_mode == 2'h3) || (e == 5 && !(gie_h || gie_l)))
            return current_pc + 21'h2;
        if (e == 5)
            return (ctrl_m[7] && !wake_high) ? 21'h18 : 21'h8;
        return 21'h0;
    endfunction
    function automatic logic [7:0] next_ctrl(input int e, input logic [7:0] c);
        case (e)
            0: c[4] = 1'b0;
            1: begin
                c[3] = c[3] | (power_mode != 2'h0);
                c[2] = c[2] & (power_mode != 2'h3);
            end
            2: begin
                c[3] = 1'b0;
                c[2] = c[2] & (power_mode != 2'h3);
            end
            5: c[2] = 1'b0;
            6: c = {2'b00, 4'hf, c[1], 1'b0};
            7: c[5] = 1'b0;
            default: c = c;
        endcase
        return c;
    endfunction
    function automatic int st_bit(input int e);
        case (e)
            0: return 1;
            1: return 2;
            2: return 3;
            3: return 4;
            4: return stk_m[2] ? 4 : 7;
            5: return 5;
            6: return 0;
            default: return 6;
        endcase
    endfunction

    // Pulse one source (7 = none, mismatch already pending) and watch the outcome
    task automatic run_event(input int e);
        logic er, el, sr, sl;
        logic [20:0] ep, sp;
        if (e < 7) begin
            @(posedge hclk);
            ev_drv <= 7'h01 << e;
            @(posedge hclk);
            ev_drv <= 7'h00;
        end
        er = restarts(e);
        el = er || e == 2 || e == 5;
        ep = next_pc(e);
        stat_m[st_bit(e)] = 1'b1;
        ctrl_m = next_ctrl(e, ctrl_m);
        stk_m[0] = stk_m[0] | (e == 3);
        stk_m[1] = stk_m[1] | (e == 4);
        sr = 1'b0;
        sl = 1'b0;
        sp = 21'h0;
        // Fixed window: pin sources need the synchroniser delay first
        for (int i = 0; i < 6; i++) begin
            #1;
            sr = sr | (core_reset === 1'b1);
            if (pc_load === 1'b1 && !sl) begin
                sl = 1'b1;
                sp = pc_value;
            end
            @(posedge hclk);
        end
        chk("core_reset", {31'h0, er}, {31'h0, sr});
        chk("pc_load", {31'h0, el}, {31'h0, sl});
        if (el) begin
            chk("pc_value", {11'h0, ep}, {11'h0, sp});
        end
        rchk(8'h00, {24'h0, ctrl_m}, "control");
        rchk(8'h04, {29'h0, stk_m}, "stack");
        chk("prio_en", {31'h0, ctrl_m[7]}, {31'h0, prio_en});
    endtask

    // ========================================
    // Main sequence: corner cases, then random traffic
    initial begin
        void'($urandom(32'h5d1f83f1));
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        ctrl_m = 8'h3c;
        stk_m = 3'h4;
        mask_m = 8'h00;
        stat_m = 8'h00;
        rchk(8'h00, 32'h3c, "control");
        rchk(8'h04, 32'h4, "stack");
        rchk(8'h14, 32'hffff0000, "config");
        ahb(1'b1, 8'h00, 32'hffffffff);
        rchk(8'h00, 32'hbf, "control");
        chk("prio_en", 32'h1, {31'h0, prio_en});
        ahb(1'b1, 8'h00, 32'h3c);
        @(posedge hclk);
        chk("prio_en", 32'h0, {31'h0, prio_en});
        ahb(1'b1, 8'h20, 32'hffffffff);
        rchk(8'h20, 32'h0, "unmapped");
        // Shadow not the complement: mismatch restart, config reloaded
        ahb(1'b1, 8'h14, 32'h00001234);
        run_event(7);
        rchk(8'h14, 32'h0000ffff, "config");
        run_event(1);
        ahb(1'b1, 8'h04, 32'h0);
        stk_m[2] = 1'b0;
        run_event(4);
        for (n = 0; n < 60; n++) begin
            r = $urandom;
            d = $urandom;
            ev = $urandom_range(6, 0);
            if (r[0]) begin
                ahb(1'b1, 8'h00, d);
                ctrl_m = (d[7:0] & 8'hb3) | (ctrl_m & 8'h0c);
            end
            ahb(1'b1, 8'h04, {29'h0, r[2], r[4:3]});
            stk_m = {r[2], stk_m[1:0] & ~r[4:3]};
            ahb(1'b1, 8'h0c, {24'h0, r[15:8]});
            mask_m = r[15:8];
            @(posedge hclk);
            power_mode <= modes[r[7:5] % 3];
            current_pc <= d[30:10];
            wake_high <= r[16];
            gie_h <= r[17];
            gie_l <= r[18];
            @(posedge hclk);
            if (ev == 3 && !stk_m[2])
                ev = 0;
            if (ev == 5 && power_mode == 2'h0)
                ev = 1;
            run_event(ev);
            rchk(8'h08, {24'h0, stat_m}, "status");
            chk("irq", {31'h0, |(stat_m & mask_m)}, {31'h0, irq});
            ahb(1'b1, 8'h08, {24'h0, r[31:24]});
            stat_m = stat_m & ~r[31:24];
        end
        // Second power-on reset in mid-run
        @(posedge hclk);
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        rchk(8'h00, 32'h3c, "control");
        rchk(8'h04, 32'h4, "stack");
        chk("irq", 32'h0, {31'h0, irq});
        report_and_stop();
    end
endmodule
